/* design/asp_defines.svh */
// Constants for the addressable scan port connect-status block
`ifndef ASP_DEFINES_SVH
`define ASP_DEFINES_SVH
`define ASP_ADDR_W 10
`define ASP_ADDR_DISCONNECT 10'h3fe
`define ASP_ADDR_SYNC 10'h3ff
`define ASP_ADDR_RESET 10'h000
`define ASP_ACK_BITS 4'ha
`define ASP_CNT_W 4
// Synchroniser reset levels, bit 0 is bypass: released so no false bypass follows reset
`define ASP_SYNC_RST_VAL 6'h01
`endif

/* design/asp_pkg.sv */
// Types shared by the addressable scan port connect-status block
package asp_pkg;
  typedef enum logic [2:0] {
    ASP_ST_OFF = 3'h0,
    ASP_ST_RESET = 3'h1,
    ASP_ST_ON = 3'h3,
    ASP_ST_MULTICAST = 3'h2,
    ASP_ST_ACK = 3'h6
  } asp_status_t;
  // Primary-side pins as one group
  typedef struct packed {
    logic serial_in;
    logic mode_select;
    logic test_clock;
    logic test_reset_n;
  } asp_primary_t;
  // Secondary-side pin drives, with the one serial-out enable (low = driving)
  typedef struct packed {
    logic serial_out;
    logic serial_out_oe_n;
    logic mode_select;
    logic test_reset_n;
  } asp_secondary_t;
  // Decoded select-protocol result delivered by the receiver
  typedef struct packed {
    logic valid;
    logic [9:0] address;
    logic hard_error;
  } asp_select_t;
endpackage

/* design/asp_sync2.sv */
// Two-flip-flop synchroniser for one pin level
`timescale 1ns/10ps
module asp_sync2 #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_r;
  logic meta_nxt;
  logic sync_r;
  logic sync_nxt;
  // First stage is read only by the second
  always_comb begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end
  assign sync_out = sync_r;
endmodule // asp_sync2

/* design/asp_connect.sv */
// Connect-status control of the addressable scan port
`timescale 1ns/10ps
`include "asp_defines.svh"
module asp_connect (
  input wire logic core_clk,
  input wire logic resetn,
  input wire asp_pkg::asp_primary_t primary,
  input wire logic secondary_serial_in,
  input wire logic bypass_n,
  input wire logic [9:0] local_address_inputs,
  input wire asp_pkg::asp_select_t select_in,
  input wire logic primary_paused,
  input wire logic secondary_paused,
  output asp_pkg::asp_secondary_t secondary,
  output logic primary_serial_out,
  output logic primary_serial_out_oe_n,
  output logic connect_indicator_n,
  output logic ack_active
);
  import asp_pkg::*;

  // ************************************************
  // Input synchronisation
  // ************************************************
  logic s_tdi;
  logic s_tms;
  logic s_tck;
  logic s_trst_n;
  logic s_sdi;
  logic s_bypass_n;
  // Idle pin levels, so the outputs see no false bypass after reset
  localparam logic [5:0] SYNC_RST = `ASP_SYNC_RST_VAL;
  logic [5:0] raw_in;
  logic [5:0] sync_in;
  assign raw_in = {primary.serial_in, primary.mode_select, primary.test_clock,
                   primary.test_reset_n, secondary_serial_in, bypass_n};
  // Every pin crosses two flops before any logic sees it
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_sync
      asp_sync2 #(
        .RST_VAL(SYNC_RST[gi])
      ) u_sync (
        .core_clk(core_clk),
        .resetn(resetn),
        .async_in(raw_in[gi]),
        .sync_out(sync_in[gi])
      );
    end
  endgenerate
  assign {s_tdi, s_tms, s_tck, s_trst_n, s_sdi, s_bypass_n} = sync_in;

  // ************************************************
  // Test-clock edge detect and protocol status
  // ************************************************
  logic tck_d_r;
  logic tck_d_nxt;
  logic tck_rise;
  asp_status_t status_r;
  asp_status_t status_nxt;
  logic tms_hold_r;
  logic tms_hold_nxt;
  logic [`ASP_CNT_W-1:0] ack_cnt_r;
  logic [`ASP_CNT_W-1:0] ack_cnt_nxt;
  logic ack_tms_r;
  logic ack_tms_nxt;
  logic rx_enable;
  assign tck_rise = s_tck & ~tck_d_r;
  // Receiver held in power-up state by bypass or test reset
  assign rx_enable = s_bypass_n & s_trst_n;

  // Status is kept across bypass so release resumes it
  always_comb begin
    tck_d_nxt = s_tck;
    status_nxt = status_r;
    tms_hold_nxt = tms_hold_r;
    ack_cnt_nxt = ack_cnt_r;
    ack_tms_nxt = ack_tms_r;
    if (!s_trst_n) begin
      // Test reset leaves the last protocol status at OFF
      status_nxt = ASP_ST_OFF;
      ack_cnt_nxt = '0;
    end else if (!rx_enable) begin
      ack_cnt_nxt = '0;
    end else if (status_r == ASP_ST_ACK) begin
      if (tck_rise) begin
        if (s_tms != ack_tms_r) begin
          status_nxt = ASP_ST_OFF;
          ack_cnt_nxt = '0;
        end else if (ack_cnt_r == `ASP_ACK_BITS - 4'h1) begin
          status_nxt = ASP_ST_ON;
          ack_cnt_nxt = '0;
        end else begin
          ack_cnt_nxt = ack_cnt_r + 4'h1;
        end
      end
    end else if (select_in.valid) begin
      if (select_in.hard_error) begin
        status_nxt = ASP_ST_OFF;
      end else if (select_in.address == `ASP_ADDR_RESET) begin
        status_nxt = ASP_ST_RESET;
      end else if (select_in.address == `ASP_ADDR_SYNC) begin
        // Sync only counts with both TAPs paused, else disconnect
        status_nxt = (primary_paused && secondary_paused) ? ASP_ST_MULTICAST : ASP_ST_OFF;
      end else if (select_in.address == `ASP_ADDR_DISCONNECT) begin
        status_nxt = ASP_ST_OFF;
      end else if (select_in.address == local_address_inputs) begin
        status_nxt = ASP_ST_ACK;
        ack_cnt_nxt = '0;
        ack_tms_nxt = s_tms;
      end else begin
        status_nxt = ASP_ST_OFF;
      end
    end
    // Mode-select level kept for OFF status
    if (status_r == ASP_ST_ON || status_r == ASP_ST_MULTICAST) begin
      tms_hold_nxt = s_tms;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tck_d_r <= 1'b0;
      status_r <= ASP_ST_OFF;
      tms_hold_r <= 1'b1;
      ack_cnt_r <= '0;
      ack_tms_r <= 1'b0;
    end else begin
      tck_d_r <= tck_d_nxt;
      status_r <= status_nxt;
      tms_hold_r <= tms_hold_nxt;
      ack_cnt_r <= ack_cnt_nxt;
      ack_tms_r <= ack_tms_nxt;
    end
  end

  // ************************************************
  // Output steering
  // ************************************************
  asp_secondary_t sec_r;
  asp_secondary_t sec_nxt;
  logic pdo_r;
  logic pdo_nxt;
  logic pdo_oe_n_r;
  logic pdo_oe_n_nxt;
  logic con_n_r;
  logic con_n_nxt;
  logic ack_r;
  logic ack_nxt;

  // Bypass overrides protocol status; test reset is checked inside the bypass arm and ahead of the status case
  always_comb begin
    sec_nxt.test_reset_n = s_trst_n;
    sec_nxt.serial_out = 1'b0;
    sec_nxt.serial_out_oe_n = 1'b1;
    sec_nxt.mode_select = tms_hold_r;
    pdo_nxt = 1'b0;
    pdo_oe_n_nxt = 1'b1;
    con_n_nxt = 1'b1;
    ack_nxt = (status_r == ASP_ST_ACK) && rx_enable;
    if (!s_bypass_n) begin
      // No wait for a test-clock edge, only the pin sampling delay
      sec_nxt.serial_out = s_tdi;
      sec_nxt.serial_out_oe_n = 1'b0;
      pdo_nxt = s_sdi;
      pdo_oe_n_nxt = 1'b0;
      sec_nxt.mode_select = s_trst_n ? s_tms : 1'b1;
      con_n_nxt = 1'b0;
    end else if (!s_trst_n) begin
      sec_nxt.mode_select = 1'b1;
      con_n_nxt = 1'b1;
    end else begin
      case (status_r)
        ASP_ST_ON: begin
          sec_nxt.serial_out = s_tdi;
          sec_nxt.serial_out_oe_n = 1'b0;
          sec_nxt.mode_select = s_tms;
          pdo_nxt = s_sdi;
          pdo_oe_n_nxt = 1'b0;
          con_n_nxt = 1'b0;
        end
        ASP_ST_MULTICAST: begin
          sec_nxt.serial_out = s_tdi;
          sec_nxt.serial_out_oe_n = 1'b0;
          sec_nxt.mode_select = s_tms;
          con_n_nxt = 1'b0;
        end
        ASP_ST_RESET: begin
          sec_nxt.mode_select = 1'b1;
        end
        ASP_ST_ACK: begin
          con_n_nxt = 1'b1;
        end
        ASP_ST_OFF: begin
          sec_nxt.mode_select = tms_hold_r;
        end
        default: begin
          con_n_nxt = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sec_r <= '{serial_out: 1'b0, serial_out_oe_n: 1'b1, mode_select: 1'b1, test_reset_n: 1'b0};
      pdo_r <= 1'b0;
      pdo_oe_n_r <= 1'b1;
      con_n_r <= 1'b1;
      ack_r <= 1'b0;
    end else begin
      sec_r <= sec_nxt;
      pdo_r <= pdo_nxt;
      pdo_oe_n_r <= pdo_oe_n_nxt;
      con_n_r <= con_n_nxt;
      ack_r <= ack_nxt;
    end
  end

  assign secondary = sec_r;
  assign primary_serial_out = pdo_r;
  assign primary_serial_out_oe_n = pdo_oe_n_r;
  assign connect_indicator_n = con_n_r;
  assign ack_active = ack_r;
endmodule // asp_connect

/* test/asp_connect_props.sv */
// Checker on the connect-status block ports
`timescale 1ns/10ps
module asp_connect_props (
  input wire logic core_clk,
  input wire logic resetn,
  input wire asp_pkg::asp_primary_t primary,
  input wire logic bypass_n,
  input wire logic [9:0] local_address_inputs,
  input wire asp_pkg::asp_select_t select_in,
  input wire logic primary_paused,
  input wire logic secondary_paused,
  input wire asp_pkg::asp_secondary_t secondary,
  input wire logic primary_serial_out_oe_n,
  input wire logic connect_indicator_n,
  input wire logic ack_active
);
  import asp_pkg::*;
  logic go;
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // Select counts only outside bypass, test reset and acknowledge
  assign go = select_in.valid && !select_in.hard_error && bypass_n && primary.test_reset_n && !ack_active;
  // ****************
  // Assertions
  // ****************
  // Pins pass two sync stages and an output stage, hence three samples
  bypass_con_a: assert property (!bypass_n [*3] |=> !connect_indicator_n)
    else $error("con not low in bypass");
  ack_con_a: assert property (ack_active && bypass_n |-> connect_indicator_n)
    else $error("con low during ack");
  trst_ms_a: assert property (!primary.test_reset_n [*3] |=> secondary.mode_select && !secondary.test_reset_n)
    else $error("test reset not passed");
  trst_float_a: assert property ((bypass_n && !primary.test_reset_n) [*3] |=> connect_indicator_n
    && primary_serial_out_oe_n && secondary.serial_out_oe_n)
    else $error("test reset not floated");
  rsa_high_a: assert property (go && select_in.address == 10'h000 |=> ##1 secondary.mode_select
    && secondary.serial_out_oe_n)
    else $error("reset address wrong");
  dsa_off_a: assert property (go && select_in.address == 10'h3fe |=> ##1 connect_indicator_n
    && primary_serial_out_oe_n && secondary.serial_out_oe_n)
    else $error("disconnect wrong");
  tsa_multi_a: assert property (go && select_in.address == 10'h3ff && primary_paused && secondary_paused
    |=> ##1 !connect_indicator_n && !secondary.serial_out_oe_n && primary_serial_out_oe_n)
    else $error("multicast wrong");
  match_ack_a: assert property (go && select_in.address == local_address_inputs
    |=> ##1 ack_active && connect_indicator_n)
    else $error("no ack on match");
endmodule // asp_connect_props
bind asp_connect asp_connect_props asp_connect_props_inst (.core_clk, .resetn, .primary, .bypass_n,
  .local_address_inputs, .select_in, .primary_paused, .secondary_paused, .secondary, .primary_serial_out_oe_n,
  .connect_indicator_n, .ack_active);

/* test/asp_chain_model.sv */
// Board scan chain behind the secondary port
`timescale 1ns/10ps
module asp_chain_model (
  input wire logic core_clk,
  input wire asp_pkg::asp_secondary_t secondary,
  output logic serial_in_back
);
  import asp_pkg::*;
  logic pat = 1'b0;
  // One-stage chain; a floated line toggles so a stale value never passes
  always @(posedge core_clk) begin
    pat <= !pat;
    serial_in_back <= secondary.serial_out_oe_n ? pat : secondary.serial_out;
  end
endmodule // asp_chain_model

/* test/test_asp_connect.sv */
// Self-checking bench for the connect-status block
`timescale 1ns/10ps
module test_asp_connect;
  import asp_pkg::*;
  localparam logic [9:0] LOCAL = 10'h155;
  logic core_clk = 0, resetn = 0, bypass_n = 1, p_pause = 0, s_pause = 0, tck_en = 0, back, pso, poe_n, con_n, ack;
  asp_primary_t prim = 4'h1;
  asp_select_t sel_in = '0;
  asp_secondary_t sec;
  int fails = 0, tests_run = 0, i;
  always #10 core_clk = !core_clk;
  // Link clock runs only while tck_en is set, in the two acknowledge scenarios
  always #80 if (tck_en) prim.test_clock = !prim.test_clock;
  asp_connect asp_connect_inst (.core_clk, .resetn, .primary(prim), .secondary_serial_in(back), .bypass_n,
    .local_address_inputs(LOCAL), .select_in(sel_in), .primary_paused(p_pause), .secondary_paused(s_pause),
    .secondary(sec), .primary_serial_out(pso), .primary_serial_out_oe_n(poe_n), .connect_indicator_n(con_n),
    .ack_active(ack));
  asp_chain_model asp_chain_model_inst (.core_clk, .secondary(sec), .serial_in_back(back));
  // ****************
  // Helpers
  // ****************
  task step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task chk(input string name, input logic seen, input logic exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %b seen %b", name, exp, seen);
    end
  endtask
  // Pins need three edges, so four cycles settle any answer
  task send(input logic [9:0] a, input logic he = 1'b0);
    sel_in = {1'b1, a, he};
    step(1);
    sel_in.valid = 1'b0;
    step(4);
  endtask
  task report_and_stop;
    $display("checks %0d fails %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ****************
  // Scenarios
  // ****************
  task t_match;
    send(LOCAL);
    chk("ack", ack, 1'b1);
    tck_en = 1;
    for (i = 0; i < 300 && con_n !== 1'b0; i++) step(1);
    tck_en = 0;
    chk("ack_len", i >= 60, 1'b1);
    chk("on_oe", sec.serial_out_oe_n | poe_n, 1'b0);
    for (int v = 0; v < 2; v++) begin
      prim.serial_in = v[0];
      step(8);
      chk("loop", pso, v[0]);
    end
    $display("match test ends");
  endtask
  task t_bypass;
    bypass_n = 0;
    step(4);
    chk("byp_con", con_n, 1'b0);
    chk("byp_oe", sec.serial_out_oe_n | poe_n, 1'b0);
    for (int v = 1; v >= 0; v--) begin
      prim.mode_select = v[0];
      step(4);
      chk("byp_ms", sec.mode_select, v[0]);
    end
    send(10'h3fe);
    bypass_n = 1;
    step(4);
    chk("byp_back", con_n, 1'b0);
    $display("bypass test ends");
  endtask
  task t_addr;
    logic [9:0] a[3] = '{10'h2aa, 10'h3fe, 10'h000};
    send(LOCAL, 1'b1);
    chk("herr_ack", ack, 1'b0);
    chk("herr_con", con_n, 1'b1);
    for (int k = 0; k < 3; k++) begin
      send(a[k]);
      chk("off_con", con_n, 1'b1);
      chk("off_oe", sec.serial_out_oe_n & poe_n, 1'b1);
      chk("off_ms", sec.mode_select, k == 2);
    end
    p_pause = 1;
    s_pause = 1;
    send(10'h3ff);
    chk("mc_con", con_n, 1'b0);
    chk("mc_oe", sec.serial_out_oe_n | !poe_n, 1'b0);
    s_pause = 0;
    send(10'h3ff);
    chk("no_sync", con_n, 1'b1);
    $display("address test ends");
  endtask
  task t_trst;
    prim.test_reset_n = 0;
    step(4);
    chk("tr_out", sec.test_reset_n, 1'b0);
    chk("tr_ms", sec.mode_select, 1'b1);
    chk("tr_float", con_n & sec.serial_out_oe_n & poe_n, 1'b1);
    send(LOCAL);
    chk("tr_ign", ack, 1'b0);
    bypass_n = 0;
    step(4);
    chk("bt_con", con_n, 1'b0);
    prim.test_reset_n = 1;
    bypass_n = 1;
    step(4);
    chk("tr_rel", sec.test_reset_n, 1'b1);
    $display("test reset test ends");
  endtask
  // Mode-select moves in mid acknowledge, well before its last bit
  task t_ack_err;
    send(LOCAL);
    tck_en = 1;
    step(16);
    chk("ae_ack", ack, 1'b1);
    prim.mode_select = 1'b1;
    step(24);
    tck_en = 0;
    chk("ae_ack_end", ack, 1'b0);
    chk("ae_con", con_n, 1'b1);
    $display("acknowledge error test ends");
  endtask
  initial begin
    step(5);
    resetn = 1;
    step(4);
    t_match;
    t_bypass;
    t_addr;
    t_trst;
    t_ack_err;
    report_and_stop;
  end
  // Whole run needs well under a thousand cycles
  initial begin
    #100000;
    fails++;
    report_and_stop;
  end
endmodule // test_asp_connect
